/* uls_line_status.sv */
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "uls_regs.svh"
// How it works
// R01: FIFO mode: error summary bit high while any error entry sits in queue.
// R02: Transmitter empty only when queue or holding and shift register are empty.
// R03: Holding empty sets when character moves to shifter, clears on write.
// R04: Holding empty with its enable raises the interrupt request.
// R05: Overrun, parity, framing or break with enable raises line status interrupt.
// R06: Break flag sets on input low a whole frame; status read clears.
// R07: Break loads one character; restart needs input high half a bit.
// R08: Framing flag sets on low first stop bit; status read clears.
// R09: After framing error the low level is taken as next start bit.
// R10: Parity flag sets on parity check failure per even select; read clears.
// R11: FIFO mode errors travel with their character, shown at queue head.
// R12: Overrun flag sets when unread character is lost; status read clears.
// R13: FIFO mode overrun only when full; new character dropped, flag immediate.
// R14: Data ready sets when character stored, clears when data read.
// R15: Software treats line status as read-only; writes are ignored here.
// R16: FIFO control is write-only, shares address with read-only identification.
// R17: Bits 7:6 pick trigger 1, 4, 8 or 14; level raises data interrupt.
// R18: Control bit 2 empties transmit queue, shifter kept, self-clearing.
// R19: Control bit 1 empties receive queue, shifter kept, self-clearing.
// R20: Bit 0 enables queues; any mode change discards both queues.
// R21: Other control bits ignored unless FIFO enable already set.
// R22: Control bit 3 and reserved bits 4, 5 change nothing.
// R23: Enable bit 2 gates line status, bit 1 gates holding empty interrupt.
// R24: Status read clears only flags shown in that read; later sets survive.
module uls_line_status #(
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_serial_input,
  output logic [7:0] o_rdata,
  output logic o_serial_output,
  output logic o_irq
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_CNT = CW'(1);

  // Wanted parity bit for a character
  function automatic logic par_bit(input logic [7:0] d, input logic even);
    par_bit = even ? ^d : ~^d;
  endfunction

  // Trigger code to byte count
  function automatic logic [4:0] trig_level(input logic [1:0] code);
    case (code)
      2'h0: trig_level = `ULS_TRIG_1;
      2'h1: trig_level = `ULS_TRIG_4;
      2'h2: trig_level = `ULS_TRIG_8;
      default: trig_level = `ULS_TRIG_14;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode
  uls_pkg::uls_bus_req_t bus;
  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  logic [15:0] div_q;
  logic [2:0] ier_q;
  logic [1:0] cfg_q;
  logic fifo_en_q;
  logic [1:0] trig_q;

  wire fcr_wr = bus.wr && bus.addr == `ULS_A_IIR_FCR; // see R16
  wire mode_chg = fcr_wr && (bus.wdata[`ULS_FCR_EN] != fifo_en_q); // see R20
  wire fcr_live = fcr_wr && fifo_en_q; // see R21
  wire rx_clear = mode_chg || (fcr_live && bus.wdata[`ULS_FCR_RXCLR]); // see R19
  wire tx_clear = mode_chg || (fcr_live && bus.wdata[`ULS_FCR_TXCLR]); // see R18
  wire lsr_rd = bus.rd && bus.addr == `ULS_A_LSR;
  wire data_rd = bus.rd && bus.addr == `ULS_A_DATA;
  wire data_wr = bus.wr && bus.addr == `ULS_A_DATA;

  // Control registers; clear bits are never stored, so they self-clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_q <= `ULS_DIV_RST;
      ier_q <= `ULS_IER_RST;
      cfg_q <= `ULS_CFG_RST;
      fifo_en_q <= 1'b0;
      trig_q <= `ULS_TRIG_RST;
    end else begin
      if (bus.wr && bus.addr == `ULS_A_DIV_LO) div_q[7:0] <= bus.wdata;
      if (bus.wr && bus.addr == `ULS_A_DIV_HI) div_q[15:8] <= bus.wdata;
      if (bus.wr && bus.addr == `ULS_A_IER) ier_q <= bus.wdata[2:0];
      if (bus.wr && bus.addr == `ULS_A_LINE_CFG) cfg_q <= bus.wdata[1:0];
      if (fcr_wr) fifo_en_q <= bus.wdata[`ULS_FCR_EN]; // see R20
      // Bits 3..5 have no home at all
      if (fcr_live) trig_q <= bus.wdata[`ULS_FCR_TRIG_HI:`ULS_FCR_TRIG_LO]; // see R17 see R22
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 16x bit-rate enable; divisor zero behaves as one
  logic [15:0] div_cnt_q;
  logic tick_q;
  wire div_end = div_cnt_q + 16'h0001 >= div_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      div_cnt_q <= div_end ? 16'h0000 : div_cnt_q + 16'h0001;
      tick_q <= div_end;
    end
  end

  // Serial input synchroniser; a change counts once stages 2 and 3 agree
  logic sin_s1_q, sin_s2_q, sin_s3_q, sin_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sin_s1_q <= 1'b1;
      sin_s2_q <= 1'b1;
      sin_s3_q <= 1'b1;
      sin_q <= 1'b1;
    end else begin
      sin_s1_q <= i_serial_input;
      sin_s2_q <= sin_s1_q;
      sin_s3_q <= sin_s2_q;
      if (sin_s2_q == sin_s3_q) sin_q <= sin_s3_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: start checked mid-bit, data sampled once per bit
  uls_pkg::uls_rx_state_t rx_state_q;
  logic [3:0] rx_ovs_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_pbit_q;
  logic rx_done_q;
  uls_pkg::uls_rx_entry_t rx_entry_q;

  wire rx_mid = rx_ovs_q == `ULS_OVS_MID;
  wire rx_last = rx_ovs_q == `ULS_OVS_LAST;
  wire pen = cfg_q[`ULS_CFG_PEN];
  wire eps = cfg_q[`ULS_CFG_EPS];
  wire stop_low = !sin_q;
  wire all_zero = rx_sh_q == 8'h00 && !(pen && rx_pbit_q);
  wire rx_brk = stop_low && all_zero; // see R06
  wire rx_par_bad = pen && (rx_pbit_q != par_bit(rx_sh_q, eps)); // see R10

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_state_q <= uls_pkg::RX_IDLE;
      rx_ovs_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_pbit_q <= 1'b0;
      rx_done_q <= 1'b0;
      rx_entry_q <= '0;
    end else begin
      rx_done_q <= 1'b0;
      if (tick_q) begin
        rx_ovs_q <= rx_ovs_q + 4'h1;
        case (rx_state_q)
          uls_pkg::RX_IDLE: begin
            rx_ovs_q <= 4'h0;
            if (!sin_q) rx_state_q <= uls_pkg::RX_START;
          end
          uls_pkg::RX_START: begin
            if (rx_mid) begin
              rx_ovs_q <= 4'h0;
              rx_bit_q <= 3'h0;
              rx_state_q <= sin_q ? uls_pkg::RX_IDLE : uls_pkg::RX_DATA;
            end
          end
          uls_pkg::RX_DATA: begin
            if (rx_last) begin
              rx_sh_q <= {sin_q, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == `ULS_BIT_LAST) rx_state_q <= pen ? uls_pkg::RX_PAR : uls_pkg::RX_STOP;
            end
          end
          uls_pkg::RX_PAR: begin
            if (rx_last) begin
              rx_pbit_q <= sin_q;
              rx_state_q <= uls_pkg::RX_STOP;
            end
          end
          uls_pkg::RX_STOP: begin
            if (rx_last) begin
              rx_done_q <= 1'b1;
              rx_entry_q <= '{brk: rx_brk, frm: stop_low, par: rx_par_bad, data: rx_sh_q}; // see R08
              rx_ovs_q <= 4'h0;
              // Break waits for idle; framing slip retries low as a start
              if (rx_brk) rx_state_q <= uls_pkg::RX_BRK; // see R07
              else if (stop_low) rx_state_q <= uls_pkg::RX_START; // see R09
              else rx_state_q <= uls_pkg::RX_IDLE;
            end
          end
          uls_pkg::RX_BRK: begin
            if (!sin_q) rx_ovs_q <= 4'h0;
            else if (rx_mid) rx_state_q <= uls_pkg::RX_IDLE; // see R07
          end
          default: rx_state_q <= uls_pkg::RX_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive queue; without FIFO mode it holds a single character
  uls_pkg::uls_rx_entry_t rx_mem [DEPTH];
  logic [PW-1:0] rx_wp_q, rx_rp_q;
  logic [CW-1:0] rx_cnt_q, err_cnt_q;

  wire [CW-1:0] rx_cap = fifo_en_q ? FULL_CNT : ONE_CNT;
  wire rx_pop = data_rd && rx_cnt_q != '0; // see R14
  wire rx_full = rx_cnt_q == rx_cap && !rx_pop;
  wire rx_push = rx_done_q && !rx_full && !rx_clear;
  wire rx_over = rx_done_q && rx_full && !rx_clear; // see R12 see R13
  wire rx_ovwr = rx_over && !fifo_en_q; // single buffer loses old character
  wire [PW-1:0] rx_rp_nx = rx_rp_q + PW'(1);
  wire uls_pkg::uls_rx_entry_t rx_head = rx_mem[rx_rp_q];
  wire in_err = rx_entry_q.brk | rx_entry_q.frm | rx_entry_q.par;
  wire head_err = rx_head.brk | rx_head.frm | rx_head.par;
  wire [CW-1:0] err_up = CW'(rx_push && in_err) + CW'(rx_ovwr && in_err);
  wire [CW-1:0] err_dn = CW'(rx_pop && head_err) + CW'(rx_ovwr && head_err);

  // New head appears: first push, pop onto waiting entry, or overwrite
  wire head_new = (rx_push && (rx_cnt_q == '0 || (rx_pop && rx_cnt_q == ONE_CNT)))
                  || (rx_pop && rx_cnt_q > ONE_CNT) || rx_ovwr;
  wire uls_pkg::uls_rx_entry_t head_nx = (rx_pop && rx_cnt_q > ONE_CNT) ? rx_mem[rx_rp_nx]
                                                                         : rx_entry_q;

  always_ff @(posedge i_clk) begin
    if (rx_push) rx_mem[rx_wp_q] <= rx_entry_q;
    if (rx_ovwr) rx_mem[rx_rp_q] <= rx_entry_q;
  end

  // Pointers and counts; clear leaves the receive shifter alone
  always_ff @(posedge i_clk) begin
    if (i_rst || rx_clear) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      rx_cnt_q <= '0;
      err_cnt_q <= '0;
    end else begin
      if (rx_push) rx_wp_q <= rx_wp_q + PW'(1);
      if (rx_pop) rx_rp_q <= rx_rp_nx;
      rx_cnt_q <= rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
      err_cnt_q <= err_cnt_q + err_up - err_dn; // see R01
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky error flags: parity, framing and break loaded from the head entry, overrun from the queue; set beats read clear
  logic oe_q, pe_q, fe_q, bi_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      oe_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      bi_q <= 1'b0;
    end else begin
      oe_q <= rx_over | (oe_q & ~lsr_rd); // see R12 see R24
      pe_q <= (head_new & head_nx.par) | (pe_q & ~lsr_rd); // see R10 see R11
      fe_q <= (head_new & head_nx.frm) | (fe_q & ~lsr_rd); // see R08 see R11
      bi_q <= (head_new & head_nx.brk) | (bi_q & ~lsr_rd); // see R06 see R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit queue and shifter
  logic [7:0] tx_mem [DEPTH];
  logic [PW-1:0] tx_wp_q, tx_rp_q;
  logic [CW-1:0] tx_cnt_q;
  uls_pkg::uls_tx_state_t tx_state_q;
  logic [3:0] tx_ovs_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic tx_par_q, tx_out_q;

  wire tx_load = tx_state_q == uls_pkg::TX_IDLE && tx_cnt_q != '0; // see R03
  wire tx_wr = data_wr && (tx_cnt_q != rx_cap || tx_load); // full writes are dropped
  wire tx_bit_end = tick_q && tx_ovs_q == `ULS_OVS_LAST;
  wire holding_empty = tx_cnt_q == '0; // see R03
  wire transmitter_empty = holding_empty && tx_state_q == uls_pkg::TX_IDLE; // see R02

  always_ff @(posedge i_clk) begin
    if (tx_wr) tx_mem[tx_wp_q] <= bus.wdata;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || tx_clear) begin
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      tx_cnt_q <= '0; // see R18
    end else begin
      if (tx_wr) tx_wp_q <= tx_wp_q + PW'(1);
      if (tx_load) tx_rp_q <= tx_rp_q + PW'(1);
      tx_cnt_q <= tx_cnt_q + CW'(tx_wr) - CW'(tx_load);
    end
  end

  // Frame sequencer; a queue clear never stops a frame in flight
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_state_q <= uls_pkg::TX_IDLE;
      tx_ovs_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h00;
      tx_par_q <= 1'b0;
      tx_out_q <= 1'b1;
    end else begin
      if (tick_q) tx_ovs_q <= tx_ovs_q + 4'h1;
      case (tx_state_q)
        uls_pkg::TX_IDLE: begin
          if (tx_load) begin
            tx_sh_q <= tx_mem[tx_rp_q];
            tx_par_q <= par_bit(tx_mem[tx_rp_q], eps);
            tx_ovs_q <= 4'h0;
            tx_out_q <= 1'b0;
            tx_state_q <= uls_pkg::TX_START;
          end
        end
        uls_pkg::TX_START: begin
          if (tx_bit_end) begin
            tx_out_q <= tx_sh_q[0];
            tx_bit_q <= 3'h0;
            tx_state_q <= uls_pkg::TX_DATA;
          end
        end
        uls_pkg::TX_DATA: begin
          if (tx_bit_end) begin
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_bit_q != `ULS_BIT_LAST) tx_out_q <= tx_sh_q[1];
            else if (pen) begin
              tx_out_q <= tx_par_q;
              tx_state_q <= uls_pkg::TX_PAR;
            end else begin
              tx_out_q <= 1'b1;
              tx_state_q <= uls_pkg::TX_STOP;
            end
          end
        end
        uls_pkg::TX_PAR: begin
          if (tx_bit_end) begin
            tx_out_q <= 1'b1;
            tx_state_q <= uls_pkg::TX_STOP;
          end
        end
        uls_pkg::TX_STOP: begin
          if (tx_bit_end) tx_state_q <= uls_pkg::TX_IDLE;
        end
        default: tx_state_q <= uls_pkg::TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, identification and interrupt request
  wire err_sum = fifo_en_q && err_cnt_q != '0; // see R01
  wire dr = rx_cnt_q != '0; // see R14
  wire [7:0] lsr_val = {err_sum, transmitter_empty, holding_empty, bi_q, fe_q, pe_q, oe_q, dr};
  wire rls_pend = ier_q[`ULS_IER_RLS] && (oe_q | pe_q | fe_q | bi_q); // see R05 see R23
  wire rda_hit = fifo_en_q ? rx_cnt_q >= CW'(trig_level(trig_q)) : dr; // see R17
  wire rda_pend = ier_q[`ULS_IER_RDA] && rda_hit;
  wire holding_empty_pend = ier_q[`ULS_IER_HOLDING_EMPTY] && holding_empty; // see R04 see R23
  wire [7:0] iir_fifo = fifo_en_q ? `ULS_IIR_FIFO : 8'h00;
  wire [7:0] iir_id = rls_pend ? `ULS_IIR_RLS : rda_pend ? `ULS_IIR_RDA :
                      holding_empty_pend ? `ULS_IIR_HOLDING_EMPTY : `ULS_IIR_NONE;

  // Read mux; the status address ignores writes entirely
  logic [7:0] rdata_d;
  always_comb begin
    case (bus.addr)
      `ULS_A_DATA: rdata_d = dr ? rx_head.data : 8'h00;
      `ULS_A_IER: rdata_d = {5'h00, ier_q};
      `ULS_A_IIR_FCR: rdata_d = iir_fifo | iir_id; // see R16
      `ULS_A_LINE_CFG: rdata_d = {6'h00, cfg_q};
      `ULS_A_DIV_LO: rdata_d = div_q[7:0];
      `ULS_A_LSR: rdata_d = lsr_val; // see R15 see R24
      `ULS_A_DIV_HI: rdata_d = div_q[15:8];
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
      o_irq <= 1'b0;
    end else begin
      o_rdata <= bus.rd ? rdata_d : 8'h00;
      o_irq <= rls_pend | rda_pend | holding_empty_pend; // see R04 see R05
    end
  end

  assign o_serial_output = tx_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_transmitter_empty_needs_holding_empty;
    lsr_val[`ULS_LSR_TRANSMITTER_EMPTY] |-> lsr_val[`ULS_LSR_HOLDING_EMPTY];
  endproperty
  a_transmitter_empty_needs_holding_empty: assert property (p_transmitter_empty_needs_holding_empty) else $error("transmitter_empty without holding_empty"); // see R02

  property p_holding_empty_drops;
    (tx_wr && tx_state_q != uls_pkg::TX_IDLE && !tx_clear) |=> !lsr_val[`ULS_LSR_HOLDING_EMPTY];
  endproperty
  a_holding_empty_drops: assert property (p_holding_empty_drops) else $error("holding_empty kept after write"); // see R03

  property p_holding_empty_irq;
    holding_empty_pend |=> o_irq;
  endproperty
  a_holding_empty_irq: assert property (p_holding_empty_irq) else $error("no irq on holding empty"); // see R04

  property p_read_clears_oe;
    (lsr_rd && oe_q && !rx_over) ##1 !rx_over |-> !oe_q;
  endproperty
  a_read_clears_oe: assert property (p_read_clears_oe) else $error("overrun not cleared"); // see R24

  property p_late_error_kept;
    (lsr_rd && rx_over) |=> oe_q;
  endproperty
  a_late_error_kept: assert property (p_late_error_kept) else $error("late overrun lost"); // see R24

  property p_break_single;
    (rx_state_q == uls_pkg::RX_BRK && $past(rx_state_q == uls_pkg::RX_BRK)) |-> !rx_done_q;
  endproperty
  a_break_single: assert property (p_break_single) else $error("extra char in break"); // see R07

  property p_fifo_overrun;
    (rx_done_q && fifo_en_q && rx_cnt_q == FULL_CNT && !rx_pop && !rx_clear)
      |=> oe_q && rx_cnt_q == FULL_CNT;
  endproperty
  a_fifo_overrun: assert property (p_fifo_overrun) else $error("overrun handling wrong"); // see R13

  property p_fcr_locked;
    (fcr_wr && !fifo_en_q) |=> trig_q == $past(trig_q);
  endproperty
  a_fcr_locked: assert property (p_fcr_locked) else $error("trigger changed while off"); // see R21

  property p_mode_flush;
    mode_chg |=> rx_cnt_q == '0 && tx_cnt_q == '0;
  endproperty
  a_mode_flush: assert property (p_mode_flush) else $error("queues kept on mode change"); // see R20

  property p_rx_clear;
    rx_clear |=> rx_cnt_q == '0 ##1 rx_cnt_q <= ONE_CNT;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive queue not emptied"); // see R19

  property p_err_sum;
    (fifo_en_q && rx_push && in_err && !rx_pop) |=> lsr_val[`ULS_LSR_ERRSUM];
  endproperty
  a_err_sum: assert property (p_err_sum) else $error("summary not set"); // see R01

  c_break: cover property (rx_done_q && rx_entry_q.brk);
  c_overrun: cover property (rx_over && fifo_en_q);
  c_tx_done: cover property (tx_state_q == uls_pkg::TX_STOP ##1 transmitter_empty);
  c_trigger: cover property (fifo_en_q && rda_pend && trig_q == 2'h3);

endmodule

/* uls_line_status_fifo_control_tb.sv */
`timescale 1ns/1ns
`include "uls_regs.svh"
module uls_line_status_fifo_control_tb;
  logic i_clk, i_rst, i_wr, i_rd, ser_in, ser_out, irq;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, rdata, got;
  int got_n, bad_count, checks, cyc, k, n0;
  uls_line_status #(.DEPTH(16)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_serial_input(ser_in),
    .o_rdata(rdata), .o_serial_output(ser_out), .o_irq(irq));
  uls_remote_model rem (.i_clk(i_clk), .i_line(ser_out), .o_line(ser_in), .o_got(got),
    .o_got_n(got_n));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task summarize();
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask
  // Strobes drop one edge later, so back-to-back calls never collide
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task rdc(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(n, rdata, e);
  endtask
  task irq_is(input logic e);
    @(posedge i_clk);
    #1;
    chk("irq", {7'h00, irq}, {7'h00, e});
  endtask
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {i_rst, i_wr, i_rd, i_addr, i_wdata, bad_count, checks} = '0;
    i_rst = 1'b1;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    // Reset value, unmapped place, writes to status ignored
    rdc(`ULS_A_LSR, 8'h60, "lsr reset");
    rdc(3'h7, 8'h00, "unmapped");
    wr(`ULS_A_LSR, 8'hff);
    rdc(`ULS_A_LSR, 8'h60, "lsr written");
    rdc(`ULS_A_DIV_LO, 8'h01, "divisor low");
    // Held character overwritten by the next one
    rem.send(8'ha5);
    rdc(`ULS_A_LSR, 8'h61, "lsr ready");
    rem.send(8'h5a);
    rdc(`ULS_A_LSR, 8'h63, "lsr overrun");
    rdc(`ULS_A_LSR, 8'h61, "lsr read clear");
    rdc(`ULS_A_DATA, 8'h5a, "rx newest");
    rdc(`ULS_A_LSR, 8'h60, "lsr data read");
    // Odd parity broken, then even parity correct, with the line status interrupt on
    wr(`ULS_A_LINE_CFG, 8'h01);
    wr(`ULS_A_IER, 8'h04);
    rem.send(8'h01, 1'b1, 1'b1);
    irq_is(1'b1);
    rdc(`ULS_A_LSR, 8'h65, "lsr parity");
    irq_is(1'b0);
    rdc(`ULS_A_LSR, 8'h61, "lsr parity clear");
    rdc(`ULS_A_DATA, 8'h01, "rx parity char");
    wr(`ULS_A_LINE_CFG, 8'h03);
    rdc(`ULS_A_LINE_CFG, 8'h03, "line config");
    rem.send(8'h01, 1'b1, 1'b1);
    rdc(`ULS_A_LSR, 8'h61, "lsr even parity");
    rdc(`ULS_A_DATA, 8'h01, "rx even char");
    // Low parity bit lands where the stop belongs: framing slip, not a break
    wr(`ULS_A_LINE_CFG, 8'h00);
    rem.send(8'h55, 1'b1, 1'b0);
    rdc(`ULS_A_LSR, 8'h69, "lsr framing");
    rdc(`ULS_A_DATA, 8'h55, "rx framing char");
    rdc(`ULS_A_LSR, 8'h60, "lsr slip no extra");
    rem.brk();
    irq_is(1'b1);
    rdc(`ULS_A_LSR, 8'h79, "lsr break");
    rdc(`ULS_A_LSR, 8'h61, "lsr break clear");
    rdc(`ULS_A_DATA, 8'h00, "rx break char");
    rdc(`ULS_A_LSR, 8'h60, "lsr one break char");
    // Enabling write drops its other bits; trigger codes walked
    wr(`ULS_A_IER, 8'h01);
    wr(`ULS_A_IIR_FCR, 8'hc1);
    rem.send(8'h01);
    irq_is(1'b1);
    wr(`ULS_A_IIR_FCR, 8'h41);
    irq_is(1'b0);
    for (k = 2; k <= 17; k++) begin
      rem.send(k[7:0]);
      if (k == 4) begin
        irq_is(1'b1);
        wr(`ULS_A_IIR_FCR, 8'h81);
        irq_is(1'b0);
        wr(`ULS_A_IIR_FCR, 8'hc1);
      end
      if (k == 13 || k == 14) irq_is(k == 14);
      if (k == 16) rdc(`ULS_A_LSR, 8'h61, "lsr full");
    end
    rdc(`ULS_A_LSR, 8'h63, "lsr fifo overrun");
    rdc(`ULS_A_LSR, 8'h61, "lsr overrun clear");
    for (k = 1; k <= 16; k++) rdc(`ULS_A_DATA, k[7:0], "rx fifo data");
    rdc(`ULS_A_LSR, 8'h60, "lsr drained");
    // Receive clear and mode change discard queued bytes
    rem.send(8'h77);
    wr(`ULS_A_IIR_FCR, 8'h03);
    rdc(`ULS_A_LSR, 8'h60, "lsr rx cleared");
    rem.send(8'h78);
    wr(`ULS_A_IIR_FCR, 8'h00);
    rdc(`ULS_A_LSR, 8'h60, "lsr mode off");
    wr(`ULS_A_IIR_FCR, 8'h39);
    // Errors travel with their own character
    wr(`ULS_A_LINE_CFG, 8'h01);
    rem.send(8'h11, 1'b1, 1'b1);
    rem.send(8'h01, 1'b1, 1'b1);
    rdc(`ULS_A_LSR, 8'he1, "lsr error queued");
    rdc(`ULS_A_DATA, 8'h11, "rx good");
    rdc(`ULS_A_LSR, 8'he5, "lsr error head");
    rdc(`ULS_A_DATA, 8'h01, "rx bad");
    rdc(`ULS_A_LSR, 8'h60, "lsr errors gone");
    wr(`ULS_A_LINE_CFG, 8'h00);
    // Transmit clear keeps the shifting character
    wr(`ULS_A_DATA, 8'h5a);
    wr(`ULS_A_DATA, 8'hc3);
    rdc(`ULS_A_LSR, 8'h00, "lsr tx busy");
    wr(`ULS_A_IIR_FCR, 8'h3d);
    rdc(`ULS_A_LSR, 8'h20, "lsr tx cleared");
    n0 = got_n;
    for (k = 0; k < 400 && got_n == n0; k++) @(posedge i_clk);
    chk("tx char", got, 8'h5a);
    repeat (200) @(posedge i_clk);
    chk("tx count", 8'(got_n - n0), 8'h01);
    rdc(`ULS_A_LSR, 8'h60, "lsr tx idle");
    wr(`ULS_A_IER, 8'h00);
    rdc(`ULS_A_IIR_FCR, 8'hc1, "identification");
    wr(`ULS_A_IER, 8'h02);
    irq_is(1'b1);
    wr(`ULS_A_IER, 8'h00);
    irq_is(1'b0);
    // Reset in mid-run with an interrupt pending and FIFO mode on
    wr(`ULS_A_IER, 8'h02);
    irq_is(1'b1);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    irq_is(1'b0);
    rdc(`ULS_A_IIR_FCR, 8'h01, "iir after reset");
    rdc(`ULS_A_LSR, 8'h60, "lsr after reset");
    summarize();
  end
endmodule

/* uls_pkg.sv */
package uls_pkg;

  // One receive queue entry: character plus its own error marks
  typedef struct packed {
    logic brk;
    logic frm;
    logic par;
    logic [7:0] data;
  } uls_rx_entry_t;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uls_bus_req_t;

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} uls_rx_state_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uls_tx_state_t;

endpackage

/* uls_regs.svh */
`ifndef ULS_REGS_SVH
`define ULS_REGS_SVH

// Register addresses on the plain port
`define ULS_A_DATA 3'h0
`define ULS_A_IER 3'h1
`define ULS_A_IIR_FCR 3'h2
`define ULS_A_LINE_CFG 3'h3
`define ULS_A_DIV_LO 3'h4
`define ULS_A_LSR 3'h5
`define ULS_A_DIV_HI 3'h6

// Line status bit positions
`define ULS_LSR_DR 0
`define ULS_LSR_OE 1
`define ULS_LSR_PE 2
`define ULS_LSR_FE 3
`define ULS_LSR_BI 4
`define ULS_LSR_HOLDING_EMPTY 5
`define ULS_LSR_TRANSMITTER_EMPTY 6
`define ULS_LSR_ERRSUM 7

// FIFO control bit positions
`define ULS_FCR_EN 0
`define ULS_FCR_RXCLR 1
`define ULS_FCR_TXCLR 2
`define ULS_FCR_TRIG_LO 6
`define ULS_FCR_TRIG_HI 7

// Interrupt enable and line config bit positions
`define ULS_IER_RDA 0
`define ULS_IER_HOLDING_EMPTY 1
`define ULS_IER_RLS 2
`define ULS_CFG_PEN 0
`define ULS_CFG_EPS 1

// Receive trigger levels in bytes
`define ULS_TRIG_1 5'h01
`define ULS_TRIG_4 5'h04
`define ULS_TRIG_8 5'h08
`define ULS_TRIG_14 5'h0e

// Identification values
`define ULS_IIR_NONE 8'h01
`define ULS_IIR_HOLDING_EMPTY 8'h02
`define ULS_IIR_RDA 8'h04
`define ULS_IIR_RLS 8'h06
`define ULS_IIR_FIFO 8'hc0

// Oversampling: last tick of a bit, last tick of half a bit
`define ULS_OVS_LAST 4'hf
`define ULS_OVS_MID 4'h7
`define ULS_BIT_LAST 3'h7

// Reset values
`define ULS_DIV_RST 16'h0001
`define ULS_IER_RST 3'h0
`define ULS_CFG_RST 2'h0
`define ULS_TRIG_RST 2'h0

`endif

/* uls_remote_model.sv */
`timescale 1ns/1ns
// Far end of the serial line: sends frames on request, collects the port's frames
module uls_remote_model (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line,
  output logic [7:0] o_got,
  output int o_got_n
);
  logic [7:0] sh;
  initial begin
    o_line = 1'b1;
    o_got = 8'h00;
    o_got_n = 0;
  end
  ////////////////////////////////////////////////////////////////////////
  // One frame, 16 clocks a bit; a wrong parity level is the caller's choice
  task automatic send(input logic [7:0] d, input logic pen = 1'b0, input logic p = 1'b0);
    logic [10:0] f;
    f = pen ? {1'b1, p, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < (pen ? 11 : 10); i++) begin
      @(posedge i_clk);
      o_line <= f[i];
      repeat (15) @(posedge i_clk);
    end
    repeat (9) @(posedge i_clk);
  endtask
  // Break: low well past a frame, then high over half a bit before more traffic
  task automatic brk();
    @(posedge i_clk);
    o_line <= 1'b0;
    repeat (200) @(posedge i_clk);
    o_line <= 1'b1;
    repeat (16) @(posedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Mid-bit sampling; parity stays off whenever the port transmits
  always begin
    @(negedge i_line);
    repeat (8) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge i_clk);
      sh[i] = i_line;
    end
    repeat (16) @(posedge i_clk);
    o_got = sh;
    o_got_n++;
  end
endmodule
